// ### stage_pkg.sv
package stage_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_FLAGS      = 4'h0;
  localparam logic [3:0] ADDR_IRQ_EN     = 4'h1;
  localparam logic [3:0] ADDR_RED_OUTCFG = 4'h2;
  localparam logic [3:0] ADDR_SEC_OUTCFG = 4'h3;
  localparam logic [3:0] ADDR_RED_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_RED_LIMA   = 4'h5;
  localparam logic [3:0] ADDR_RED_LIMB   = 4'h6;
  localparam logic [3:0] ADDR_RED_TOP    = 4'h7;
  localparam logic [3:0] ADDR_FUSES      = 4'h8;
  // Flag register field positions
  localparam int FLAG_OUT_B   = 7;
  localparam int FLAG_OUT_A   = 6;
  localparam int FLAG_SYNC    = 5;
  localparam int FLAG_EV_B    = 4;
  localparam int FLAG_EV_A    = 3;
  localparam int FLAG_RAMP_HI = 2;
  localparam int FLAG_RAMP_LO = 1;
  localparam int FLAG_EOC     = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Interrupt enable field positions
  localparam int IEN_SYNC = 5;
  localparam int IEN_EV_B = 4;
  localparam int IEN_EV_A = 3;
  localparam int IEN_EOC  = 0;
  // Fuse byte bit positions
  localparam int FUSE_SECOND = 7;
  localparam int FUSE_AUX    = 6;
  localparam int FUSE_RED    = 5;
  localparam int FUSE_LEVEL  = 4;
  localparam int FUSE_INPUT  = 3;
  localparam logic [7:0] FUSES_DEFAULT = 8'hFF;
  // Reduced stage control fields
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_AUTORUN  = 1;
  localparam int CTRL_MODE_LO  = 2;
  localparam int CTRL_POL_A    = 4;
  localparam int CTRL_POL_B    = 5;
  localparam int CTRL_SEL_A    = 6;
  localparam int CTRL_SEL_B    = 7;
  localparam int CNT_W         = 12;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  typedef enum logic [1:0] {MODE_ONE, MODE_TWO, MODE_FOUR, MODE_CENTER} run_mode_t;
endpackage

// ### half_input.sv
`timescale 1ns/1ps
`default_nettype none
module half_input (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  // Inputs
  input  wire logic i_sel,
  input  wire logic i_in0,
  input  wire logic i_in1,
  // Event
  output logic      o_event
);
  logic prev_reg;
  logic cur;
  assign cur = i_sel ? i_in1 : i_in0;
  // Rising edge of the selected input is the half's event
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_reg <= 1'b0;
      o_event  <= 1'b0;
    end else if (i_ce) begin
      prev_reg <= cur;
      o_event  <= cur & ~prev_reg;
    end
  end
endmodule // half_input
`default_nettype wire

// ### half_wave.sv
`timescale 1ns/1ps
`default_nettype none
module half_wave #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_ce,
  // Counter and limits
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_cnt,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  input  wire logic         i_pol,
  // Output
  output logic              o_wave
);
  // Active while counter lies in [set, clr); polarity flips it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wave <= 1'b0;
    end else if (i_ce) begin
      o_wave <= (i_run && i_cnt >= i_set && i_cnt < i_clr) ^ i_pol;
    end
  end
endmodule // half_wave
`default_nettype wire

// ### power_stage_flags_reset_ctl.sv
//Contract
// - Output B toggle sets bit 7
// - Output A toggle sets bit 6
// - Flags clear only on write-one
// - Auto-run mismatch with upstream sets bit 5
// - Block B input event sets bit 4
// - Block A input event sets bit 3
// - Event flags set regardless of enables
// - Ramp number captured at latest event
// - Whole cycle end sets bit 0
// - Level fuse: 0 low, 1 high
// - Reduced fuse forces outputs until configured
// - Second fuse forces outputs 0,1 until configured
// - Aux fuse forces outputs 2,3 until configured
// - Input fuse forces pull-ups during reset
// - Never pull up reduced input B
// - Fuses default unprogrammed, forced level high
// - One up/down counter between register limits
// - Half A drives out 0, B out 1
// - Each half has own input module
// - Per-output polarity is programmable
// - Sync error with enable raises request
// - Cycle end with enable raises request
`timescale 1ns/1ps
`default_nettype none
module power_stage_flags_reset_ctl #(
  parameter int CNT_W = stage_pkg::CNT_W
) (
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Fuse byte, static
  input  wire logic [7:0] i_fuses,
  // Stage inputs
  input  wire logic       i_red_in,
  input  wire logic       i_red_in_a,
  input  wire logic       i_red_in_b,
  input  wire logic       i_upstream_eoc,
  // Second stage outputs from its generator
  input  wire logic [3:0] i_second_wave,
  // Pins
  output logic            o_reduced_output_0,
  output logic            o_reduced_output_1,
  output logic      [3:0] o_second_output,
  output logic      [3:0] o_pullup_en,
  output logic            o_irq
);
  logic [7:0]       flags_reg;
  logic [7:0]       ien_reg;
  logic [7:0]       ctrl_reg;
  logic [7:0]       fuse_reg;
  logic [CNT_W-1:0] lim_a_reg;
  logic [CNT_W-1:0] lim_b_reg;
  logic [CNT_W-1:0] top_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             dir_down_reg;
  logic [1:0]       ramp_reg;
  logic             red_cfg_done_reg;
  logic             sec_cfg_done_reg;
  logic             in_reset_reg;
  logic             wave_a;
  logic             wave_b;
  logic             wave_a_prev_reg;
  logic             wave_b_prev_reg;
  logic             ev_a;
  logic             ev_b;
  logic             eoc;
  logic             sync_err;
  logic [7:0]       set_mask;
  logic [7:0]       clr_mask;
  logic [7:0]       flags_next;
  logic [7:0]       rdata_next;
  stage_pkg::run_mode_t mode;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  assign mode = stage_pkg::run_mode_t'(ctrl_reg[stage_pkg::CTRL_MODE_LO +: 2]);

  // Register writes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ien_reg   <= 8'h00;
      ctrl_reg  <= stage_pkg::CTRL_RESET;
      lim_a_reg <= '0;
      lim_b_reg <= '0;
      top_reg   <= '1;
    end else if (i_ce && i_wr) begin
      if (hit(i_addr, stage_pkg::ADDR_IRQ_EN)) begin
        ien_reg <= i_wdata;
      end
      if (hit(i_addr, stage_pkg::ADDR_RED_CTRL)) begin
        ctrl_reg <= i_wdata;
      end
      if (hit(i_addr, stage_pkg::ADDR_RED_LIMA)) begin
        lim_a_reg <= CNT_W'({i_wdata, 4'h0});
      end
      if (hit(i_addr, stage_pkg::ADDR_RED_LIMB)) begin
        lim_b_reg <= CNT_W'({i_wdata, 4'h0});
      end
      if (hit(i_addr, stage_pkg::ADDR_RED_TOP)) begin
        top_reg <= CNT_W'({i_wdata, 4'hF});
      end
    end
  end

  // Fuses sampled after reset release; default is all unprogrammed
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fuse_reg     <= stage_pkg::FUSES_DEFAULT;
      in_reset_reg <= 1'b1;
    end else if (i_ce && in_reset_reg) begin
      fuse_reg     <= i_fuses;
      in_reset_reg <= 1'b0;
    end
  end

  // Output configuration written releases the forced levels
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      red_cfg_done_reg <= 1'b0;
      sec_cfg_done_reg <= 1'b0;
    end else if (i_ce && i_wr) begin
      if (hit(i_addr, stage_pkg::ADDR_RED_OUTCFG)) begin
        red_cfg_done_reg <= 1'b1;
      end
      if (hit(i_addr, stage_pkg::ADDR_SEC_OUTCFG)) begin
        sec_cfg_done_reg <= 1'b1;
      end
    end
  end

  // Single up/down counter, ramps number the ramp within the cycle: 0-3 in four-ramp, 0-1 in two-ramp and centre
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg      <= '0;
      dir_down_reg <= 1'b0;
      ramp_reg     <= 2'b00;
    end else if (i_ce) begin
      if (!ctrl_reg[stage_pkg::CTRL_RUN]) begin
        cnt_reg      <= '0;
        dir_down_reg <= 1'b0;
        ramp_reg     <= 2'b00;
      end else if (!dir_down_reg) begin
        if (cnt_reg >= top_reg) begin
          if (mode == stage_pkg::MODE_CENTER) begin
            dir_down_reg <= 1'b1;
            cnt_reg      <= cnt_reg - 1'b1;
            ramp_reg     <= 2'b01;
          end else begin
            cnt_reg <= '0;
            case (mode)
              stage_pkg::MODE_ONE:  ramp_reg <= 2'b00;
              stage_pkg::MODE_TWO:  ramp_reg <= {1'b0, ~ramp_reg[0]};
              default:              ramp_reg <= ramp_reg + 2'b01;
            endcase
          end
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end else begin
        if (cnt_reg == '0) begin
          dir_down_reg <= 1'b0;
          cnt_reg      <= cnt_reg + 1'b1;
          ramp_reg     <= 2'b00;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end

  // End of whole cycle: last ramp wraps, or centre count reaches zero
  always_comb begin
    case (mode)
      stage_pkg::MODE_ONE:    eoc = cnt_reg >= top_reg && !dir_down_reg;
      stage_pkg::MODE_TWO:    eoc = cnt_reg >= top_reg && ramp_reg[0];
      stage_pkg::MODE_FOUR:   eoc = cnt_reg >= top_reg && ramp_reg == 2'b11;
      default:                eoc = dir_down_reg && cnt_reg == '0;
    endcase
    eoc = eoc && ctrl_reg[stage_pkg::CTRL_RUN];
  end

  // Auto-run: own cycle end must coincide with upstream's
  assign sync_err = ctrl_reg[stage_pkg::CTRL_AUTORUN] && (eoc != i_upstream_eoc);

  // Half A and half B, each with its own input module
  half_input u_in_a (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_sel   (ctrl_reg[stage_pkg::CTRL_SEL_A]),
    .i_in0   (i_red_in),
    .i_in1   (i_red_in_a),
    .o_event (ev_a)
  );

  half_input u_in_b (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_sel   (ctrl_reg[stage_pkg::CTRL_SEL_B]),
    .i_in0   (i_red_in),
    .i_in1   (i_red_in_b),
    .o_event (ev_b)
  );

  half_wave #(.W(CNT_W)) u_wave_a (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_run  (ctrl_reg[stage_pkg::CTRL_RUN]),
    .i_cnt  (cnt_reg),
    .i_set  (lim_a_reg),
    .i_clr  (lim_b_reg),
    .i_pol  (ctrl_reg[stage_pkg::CTRL_POL_A]),
    .o_wave (wave_a)
  );

  half_wave #(.W(CNT_W)) u_wave_b (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_run  (ctrl_reg[stage_pkg::CTRL_RUN]),
    .i_cnt  (cnt_reg),
    .i_set  (lim_b_reg),
    .i_clr  (top_reg),
    .i_pol  (ctrl_reg[stage_pkg::CTRL_POL_B]),
    .o_wave (wave_b)
  );

  // Pins, forced level held until the matching configuration write
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reduced_output_0 <= 1'b1;
      o_reduced_output_1 <= 1'b1;
      o_second_output    <= 4'hF;
      wave_a_prev_reg    <= 1'b0;
      wave_b_prev_reg    <= 1'b0;
    end else if (i_ce) begin
      wave_a_prev_reg <= wave_a;
      wave_b_prev_reg <= wave_b;
      if (!fuse_reg[stage_pkg::FUSE_RED] && !red_cfg_done_reg) begin
        o_reduced_output_0 <= fuse_reg[stage_pkg::FUSE_LEVEL];
        o_reduced_output_1 <= fuse_reg[stage_pkg::FUSE_LEVEL];
      end else begin
        o_reduced_output_0 <= wave_a;
        o_reduced_output_1 <= wave_b;
      end
      if (!fuse_reg[stage_pkg::FUSE_SECOND] && !sec_cfg_done_reg) begin
        o_second_output[1:0] <= {2{fuse_reg[stage_pkg::FUSE_LEVEL]}};
      end else begin
        o_second_output[1:0] <= i_second_wave[1:0];
      end
      if (!fuse_reg[stage_pkg::FUSE_AUX] && !sec_cfg_done_reg) begin
        o_second_output[3:2] <= {2{fuse_reg[stage_pkg::FUSE_LEVEL]}};
      end else begin
        o_second_output[3:2] <= i_second_wave[3:2];
      end
    end
  end

  // Pull-ups in reset: no reset of its own, it samples the reset pin and the raw fuse
  // byte, since the fuse copy is still at its default then. Needs the clock running in
  // reset and trails the reset pin by one edge. Bit 0 up: red, red A, red B, second.
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (!i_rstn) begin
        o_pullup_en <= {~i_fuses[stage_pkg::FUSE_INPUT], 1'b0,
                        {2{~i_fuses[stage_pkg::FUSE_INPUT]}}};
      end else begin
        o_pullup_en <= 4'h0;
      end
    end
  end

  // Event flag collection
  always_comb begin
    set_mask = 8'h00;
    set_mask[stage_pkg::FLAG_OUT_B] = wave_b != wave_b_prev_reg;
    set_mask[stage_pkg::FLAG_OUT_A] = wave_a != wave_a_prev_reg;
    set_mask[stage_pkg::FLAG_SYNC]  = sync_err;
    set_mask[stage_pkg::FLAG_EV_B]  = ev_b;
    set_mask[stage_pkg::FLAG_EV_A]  = ev_a;
    set_mask[stage_pkg::FLAG_EOC]   = eoc;
    clr_mask = (i_wr && hit(i_addr, stage_pkg::ADDR_FLAGS)) ? i_wdata : 8'h00;
    clr_mask[stage_pkg::FLAG_RAMP_HI] = 1'b0;
    clr_mask[stage_pkg::FLAG_RAMP_LO] = 1'b0;
    flags_next = (flags_reg & ~clr_mask) | set_mask;
    if (ev_a || ev_b) begin
      flags_next[stage_pkg::FLAG_RAMP_HI:stage_pkg::FLAG_RAMP_LO] = ramp_reg;
    end else begin
      flags_next[stage_pkg::FLAG_RAMP_HI:stage_pkg::FLAG_RAMP_LO] =
        flags_reg[stage_pkg::FLAG_RAMP_HI:stage_pkg::FLAG_RAMP_LO];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_reg <= stage_pkg::FLAGS_RESET;
    end else if (i_ce) begin
      flags_reg <= flags_next;
    end
  end

  // Interrupt request from flags gated by enables
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= (flags_reg[stage_pkg::FLAG_SYNC] & ien_reg[stage_pkg::IEN_SYNC]) |
               (flags_reg[stage_pkg::FLAG_EOC]  & ien_reg[stage_pkg::IEN_EOC])  |
               (flags_reg[stage_pkg::FLAG_EV_B] & ien_reg[stage_pkg::IEN_EV_B]) |
               (flags_reg[stage_pkg::FLAG_EV_A] & ien_reg[stage_pkg::IEN_EV_A]);
    end
  end

  // Read data, valid the cycle after the strobe
  always_comb begin
    case (i_addr)
      stage_pkg::ADDR_FLAGS:    rdata_next = flags_reg;
      stage_pkg::ADDR_IRQ_EN:   rdata_next = ien_reg;
      stage_pkg::ADDR_RED_CTRL: rdata_next = ctrl_reg;
      stage_pkg::ADDR_RED_TOP:  rdata_next = top_reg[CNT_W-1 -: 8];
      stage_pkg::ADDR_FUSES:    rdata_next = fuse_reg;
      default:                  rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rdata_next : 8'h00;
    end
  end
endmodule // power_stage_flags_reset_ctl
`default_nettype wire

// ### stage_flags_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module stage_flags_chk (
  // Clock, reset, register port
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_ce,
  input wire logic [3:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Fuses and waves
  input wire logic [7:0] i_fuses,
  input wire logic [3:0] i_second_wave,
  // Pins
  input wire logic       o_reduced_output_0,
  input wire logic       o_reduced_output_1,
  input wire logic [3:0] o_second_output,
  input wire logic [3:0] o_pullup_en,
  input wire logic       o_irq
);
  logic [1:0] ecnt;
  logic       red_wr;
  logic       sec_wr;
  logic [3:0] wave_q;
  logic       lvl;
  assign lvl = i_fuses[stage_pkg::FUSE_LEVEL];
  // Forced checks wait until the sampled fuses have reached the pins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ecnt   <= 2'h0;
      red_wr <= 1'b0;
      sec_wr <= 1'b0;
    end else if (i_ce) begin
      if (ecnt != 2'h3) ecnt <= ecnt + 2'h1;
      if (i_wr && i_addr == stage_pkg::ADDR_RED_OUTCFG) red_wr <= 1'b1;
      if (i_wr && i_addr == stage_pkg::ADDR_SEC_OUTCFG) sec_wr <= 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    wave_q <= i_second_wave;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_red_forced;
    ecnt == 2'h3 && !i_fuses[stage_pkg::FUSE_RED] && !red_wr
      |-> o_reduced_output_0 == lvl && o_reduced_output_1 == lvl;
  endproperty
  a_red_forced: assert property (p_red_forced) else $error("reduced pins not forced");
  property p_sec_forced;
    ecnt == 2'h3 && !i_fuses[stage_pkg::FUSE_SECOND] && !sec_wr |-> o_second_output[1:0] == {2{lvl}};
  endproperty
  a_sec_forced: assert property (p_sec_forced) else $error("second pins 0 1 not forced");
  property p_aux_forced;
    ecnt == 2'h3 && !i_fuses[stage_pkg::FUSE_AUX] && !sec_wr |-> o_second_output[3:2] == {2{lvl}};
  endproperty
  a_aux_forced: assert property (p_aux_forced) else $error("second pins 2 3 not forced");
  property p_sec_free;
    ecnt != 2'h0 && i_fuses[stage_pkg::FUSE_SECOND] && $past(i_ce) |-> o_second_output[1:0] == wave_q[1:0];
  endproperty
  a_sec_free: assert property (p_sec_free) else $error("second pins 0 1 not following");
  property p_aux_free;
    ecnt != 2'h0 && i_fuses[stage_pkg::FUSE_AUX] && $past(i_ce) |-> o_second_output[3:2] == wave_q[3:2];
  endproperty
  a_aux_free: assert property (p_aux_free) else $error("second pins 2 3 not following");
  property p_fuse_read;
    $past(i_rd) && $past(i_ce) && $past(i_addr) == stage_pkg::ADDR_FUSES && ecnt == 2'h3
      |-> o_rdata == i_fuses;
  endproperty
  a_fuse_read: assert property (p_fuse_read) else $error("fuse byte read wrong");
  property p_pullup;
    disable iff (1'b0)
      $past(i_ce) && ($past(i_rstn) || $past(i_fuses[stage_pkg::FUSE_INPUT]))
      |-> o_pullup_en == 4'h0;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up outside reset window");
  property p_pullup_forced;
    disable iff (1'b0)
      $past(i_ce) && !$past(i_rstn) && !$past(i_fuses[stage_pkg::FUSE_INPUT])
      |-> o_pullup_en == 4'hB;
  endproperty
  a_pullup_forced: assert property (p_pullup_forced) else $error("pull-up wrong in reset");
  property p_quiet;
    disable iff (1'b0) !i_rstn |-> o_rdata == 8'h00 && !o_irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("activity during reset");
  c_release: cover property (red_wr && !i_fuses[stage_pkg::FUSE_RED]);
  c_aux: cover property (ecnt == 2'h3 && !i_fuses[stage_pkg::FUSE_AUX] && !sec_wr);
  c_irq: cover property (o_irq);
endmodule // stage_flags_chk
bind power_stage_flags_reset_ctl stage_flags_chk i_stage_flags_chk (
  .i_clk, .i_rstn, .i_ce, .i_addr, .i_wr, .i_rd, .o_rdata, .i_fuses, .i_second_wave,
  .o_reduced_output_0, .o_reduced_output_1, .o_second_output, .o_pullup_en, .o_irq
);
`default_nettype wire

// ### bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_model #(
  parameter int LAG = 1
) (
  // Clock and trip requests
  input  wire logic i_clk,
  input  wire logic i_trip_a,
  input  wire logic i_trip_b,
  // Comparator outputs
  output logic      o_sense,
  output logic      o_sense_a,
  output logic      o_sense_b
);
  // Comparators lag the load, so the stage sees late edges
  logic [3:0] sa = 4'h0;
  logic [3:0] sb = 4'h0;
  always_ff @(posedge i_clk) begin
    sa <= {sa[2:0], i_trip_a};
    sb <= {sb[2:0], i_trip_b};
  end
  assign o_sense   = sa[LAG] & sb[LAG];
  assign o_sense_a = sa[LAG];
  assign o_sense_b = sb[LAG];
endmodule // bridge_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [3:0] FL = stage_pkg::ADDR_FLAGS;
  localparam logic [3:0] CT = stage_pkg::ADDR_RED_CTRL;
  localparam logic [3:0] IE = stage_pkg::ADDR_IRQ_EN;
  logic       i_clk = 1'b0;
  logic       i_rstn = 1'b1;
  logic       i_ce = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] i_fuses = 8'hFF;
  logic       i_upstream_eoc = 1'b0;
  logic [3:0] i_second_wave = 4'h0;
  logic       trip_a = 1'b0;
  logic       trip_b = 1'b0;
  logic       sense, sense_a, sense_b, red0, red1, o_irq;
  logic [7:0] o_rdata;
  logic [3:0] o_second_output, o_pullup_en;
  int         fails = 0;
  int         checks = 0;
  always #10 i_clk = ~i_clk;
  power_stage_flags_reset_ctl i_power_stage_flags_reset_ctl (
    .i_clk, .i_rstn, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_fuses,
    .i_red_in(sense), .i_red_in_a(sense_a), .i_red_in_b(sense_b), .i_upstream_eoc,
    .i_second_wave, .o_reduced_output_0(red0), .o_reduced_output_1(red1),
    .o_second_output, .o_pullup_en, .o_irq);
  bridge_model #(.LAG(2)) i_bridge_model (.i_clk, .i_trip_a(trip_a), .i_trip_b(trip_b),
    .o_sense(sense), .o_sense_a(sense_a), .o_sense_b(sense_b));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic do_reset(input logic [7:0] f);
    @(posedge i_clk);
    i_fuses <= f;
    i_rstn  <= 1'b0;
    tick(20);
    #1 chk("pullup", {4'h0, o_pullup_en}, f[3] ? 8'h00 : 8'h0B);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    tick(4);
  endtask
  task automatic t_defaults();
    logic [7:0] d;
    rd(FL, d);
    chk("flags", d, stage_pkg::FLAGS_RESET);
    rd(stage_pkg::ADDR_FUSES, d);
    chk("fuses", d, stage_pkg::FUSES_DEFAULT);
    rd(4'hF, d);
    chk("unmapped", d, 8'h00);
    $display("defaults done");
  endtask
  task automatic t_activity();
    logic [7:0] d;
    wr(CT, 8'h10);
    tick(3);
    rd(FL, d);
    chk("out a rise", d, 8'h40);
    chk("pins a", {6'h0, red1, red0}, 8'h01);
    wr(FL, 8'h00);
    i_ce <= 1'b0;
    wr(FL, 8'h40);
    i_ce <= 1'b1;
    rd(FL, d);
    chk("zero or idle write", d, 8'h40);
    wr(FL, 8'h40);
    wr(CT, 8'h30);
    tick(3);
    rd(FL, d);
    chk("out b rise", d, 8'h80);
    chk("pins b", {6'h0, red1, red0}, 8'h03);
    wr(FL, 8'h80);
    wr(CT, 8'h10);
    tick(3);
    rd(FL, d);
    chk("out b fall", d, 8'h80);
    wr(CT, 8'h00);
    tick(3);
    rd(FL, d);
    chk("out a fall", d, 8'hC0);
    wr(FL, 8'hFF);
    rd(FL, d);
    chk("cleared", d, 8'h00);
    $display("activity done");
  endtask
  task automatic t_events();
    logic [7:0] d;
    wr(CT, 8'hC0);
    trip_a <= 1'b1;
    tick(6);
    rd(FL, d);
    chk("event a", d, 8'h08);
    tick(1);
    trip_b <= 1'b1;
    tick(6);
    rd(FL, d);
    chk("event b", d, 8'h18);
    wr(FL, 8'h18);
    trip_a <= 1'b0;
    trip_b <= 1'b0;
    rd(FL, d);
    chk("events cleared", d, 8'h00);
    $display("events done");
  endtask
  task automatic t_cycle();
    logic [7:0] d;
    wr(stage_pkg::ADDR_RED_TOP, 8'h01);
    wr(IE, 8'h01);
    wr(CT, 8'hC1);
    tick(300);
    rd(FL, d);
    chk("end of cycle", d & 8'h01, 8'h01);
    chk("eoc request", {7'h0, o_irq}, 8'h01);
    wr(CT, 8'hC0);
    wr(FL, 8'hFF);
    wr(IE, 8'h00);
    tick(3);
    #1 chk("request gone", {7'h0, o_irq}, 8'h00);
    $display("cycle done");
  endtask
  task automatic t_sync();
    logic [7:0] d;
    wr(IE, 8'h20);
    wr(CT, 8'hC3);
    i_upstream_eoc <= 1'b1;
    tick(1);
    i_upstream_eoc <= 1'b0;
    tick(300);
    rd(FL, d);
    chk("sync error", d & 8'h20, 8'h20);
    chk("sync request", {7'h0, o_irq}, 8'h01);
    wr(CT, 8'hC0);
    wr(FL, 8'hFF);
    wr(IE, 8'h00);
    $display("sync done");
  endtask
  task automatic t_fuses();
    logic [7:0] fz [3] = '{8'h0F, 8'hBF, 8'h67};
    logic [7:0] f, d;
    logic [3:0] w, e;
    logic       lv;
    for (int k = 0; k < 3; k++) begin
      f = fz[k];
      lv = f[4];
      w = lv ? 4'h0 : 4'hF;
      e = {f[6] ? w[3:2] : {2{lv}}, f[7] ? w[1:0] : {2{lv}}};
      i_second_wave <= w;
      do_reset(f);
      #1 chk("forced", {4'h0, o_second_output}, {4'h0, e});
      if (!f[5]) chk("red forced", {6'h0, red1, red0}, {6'h0, lv, lv});
      rd(stage_pkg::ADDR_FUSES, d);
      chk("fuse read", d, f);
      wr(stage_pkg::ADDR_SEC_OUTCFG, 8'h00);
      wr(stage_pkg::ADDR_RED_OUTCFG, 8'h00);
      tick(2);
      #1 chk("released", {4'h0, o_second_output}, {4'h0, w});
    end
    $display("fuses done");
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    do_reset(8'hFF);
    t_defaults();
    t_activity();
    t_events();
    t_cycle();
    t_sync();
    t_fuses();
    print_verdict();
  end
  // Tests need under 2000 cycles, so a hang is cut well before the run limit
  initial begin
    tick(5000);
    fails++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
